// >>> pkg/mpch_pkg.sv
// Constants for the motion parameter command handler.
// Assumes frames arrive as one byte per strobe, already framed.
package mpch_pkg;
  localparam int FRAME_BYTES = 9;
  localparam logic [7:0] CMD_SET_AXIS = 8'h05;
  localparam logic [7:0] CMD_GET_AXIS = 8'h06;
  localparam logic [7:0] CMD_STORE_AXIS = 8'h07;
  localparam logic [7:0] CMD_RESTORE_AXIS = 8'h08;
  localparam logic [7:0] CMD_SET_GLOBAL = 8'h09;
  localparam logic [7:0] CMD_GET_GLOBAL = 8'h0a;
  localparam logic [7:0] CMD_STORE_GLOBAL = 8'h0b;
  localparam logic [7:0] CMD_RESTORE_GLOBAL = 8'h0c;
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [7:0] GP_SERIAL_ADDR = 8'h42;
  localparam logic [7:0] AP_ACTUAL_POS = 8'h01;
  localparam logic [7:0] AP_MAX_POS_SPEED = 8'h04;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] SERIAL_ADDR_RST = 8'h01;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_INSTR = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;
  localparam logic [3:0] IDX_V3 = 4'h4;
  localparam logic [3:0] IDX_V0 = 4'h7;
  localparam logic [3:0] IDX_SUM = 4'h8;
  typedef enum logic [3:0] {
    MPCH_BOOT = 4'b0001,
    MPCH_RECV = 4'b0010,
    MPCH_EXEC = 4'b0100,
    MPCH_DONE = 4'b1000
  } mpch_state_t;
endpackage

// >>> rtl/mpch_top.sv
// Parameter access command interpreter: axis, global and stored copies.
// Assumes bytes arrive synchronous to clk_sys_i with a one-cycle strobe.
// How it works
// - Frame: addr, instr, type, bank, value MSB first
// - Instruction 5 writes axis parameter
// - Instruction 6 direct mode replies, accumulator kept
// - Standalone axis read also loads accumulator
// - Instruction 7 stores axis parameter copy
// - Instruction 8 reloads axis parameter copy
// - Axis parameters restored after reset only when auto_restore_i is set
// - Instruction 9 writes global, banks 0/2/3
// - Bank 0 writes auto-committed to storage
// - Instruction 10 reads global into accumulator
// - Every command replies, status 100 okay
// - Global store saves user variables
// - Power-on restore automatic or on request
// - Global 66 bank 0 is serial address
// - Axis parameter 1 returns actual position
// - Axis parameter 4 sets positioning speed
// - Axis writes volatile until explicitly stored
module mpch_top
  import mpch_pkg::*;
#(
  parameter int N_PARAM = 256
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Mode and configuration
  input wire logic standalone_i,
  input wire logic auto_restore_i,
  // Command bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Motor side
  input wire logic [31:0] actual_pos_i,
  output logic [31:0] max_pos_speed_o,
  output logic [7:0] serial_addr_o,
  // Reply
  output logic reply_valid_o,
  output logic [7:0] reply_status_o,
  output logic [7:0] reply_instr_o,
  output logic [31:0] reply_value_o,
  output logic [31:0] accu_o,
  output logic busy_o
);

  logic [31:0] axis_work [N_PARAM];
  logic [31:0] axis_nv [N_PARAM];
  logic [31:0] glob_work [4][N_PARAM];
  logic [31:0] glob_nv [4][N_PARAM];
  mpch_state_t state;
  logic [3:0] idx;
  logic [7:0] sum;
  logic [7:0] instr;
  logic [7:0] ptype;
  logic [7:0] bank;
  logic [31:0] value;
  logic sum_ok;
  logic [8:0] boot_idx;
  logic bank_ok;
  logic [31:0] axis_rd;
  logic [31:0] glob_rd;

  function automatic logic is_bank(input logic [7:0] b);
    return b == BANK_MODULE || b == BANK_USER || b == BANK_IRQ;
  endfunction

  assign bank_ok = is_bank(bank);
  assign busy_o = state != MPCH_RECV;
  assign max_pos_speed_o = axis_work[AP_MAX_POS_SPEED];
  assign serial_addr_o = glob_work[BANK_MODULE[1:0]][GP_SERIAL_ADDR][7:0];
  // Actual position comes from the motor, not storage
  assign axis_rd = (ptype == AP_ACTUAL_POS) ? actual_pos_i : axis_work[ptype];
  assign glob_rd = glob_work[bank[1:0]][ptype];

  // Frame receive and sequencing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= MPCH_BOOT;
      idx <= 4'h0;
      sum <= 8'h00;
      instr <= 8'h00;
      ptype <= 8'h00;
      bank <= 8'h00;
      value <= 32'h0;
      sum_ok <= 1'b0;
      boot_idx <= 9'h000;
    end else begin
      case (state)
        MPCH_BOOT: begin
          boot_idx <= boot_idx + 9'h001;
          if (boot_idx == 9'(N_PARAM - 1)) begin
            state <= MPCH_RECV;
          end
        end
        MPCH_RECV: begin
          if (rx_valid_i) begin
            if (idx == IDX_SUM) begin
              sum_ok <= (rx_data_i == sum);
              idx <= 4'h0;
              sum <= 8'h00;
              state <= MPCH_EXEC;
            end else begin
              sum <= sum + rx_data_i;
              idx <= idx + 4'h1;
              if (idx == IDX_INSTR) begin
                instr <= rx_data_i;
              end else if (idx == IDX_TYPE) begin
                ptype <= rx_data_i;
              end else if (idx == IDX_BANK) begin
                bank <= rx_data_i;
              end else if (idx >= IDX_V3 && idx <= IDX_V0) begin
                value <= {value[23:0], rx_data_i};
              end
            end
          end
        end
        MPCH_EXEC: begin
          state <= MPCH_DONE;
        end
        default: begin
          state <= MPCH_RECV;
        end
      endcase
    end
  end

  // Axis parameter memories; working copy is volatile
  always_ff @(posedge clk_sys_i) begin
    if (state == MPCH_BOOT && auto_restore_i) begin
      axis_work[boot_idx[7:0]] <= axis_nv[boot_idx[7:0]];
    end else if (state == MPCH_EXEC && sum_ok && bank == BANK_MODULE) begin
      if (instr == CMD_SET_AXIS) begin
        axis_work[ptype] <= value;
      end else if (instr == CMD_RESTORE_AXIS) begin
        axis_work[ptype] <= axis_nv[ptype];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (state == MPCH_EXEC && sum_ok && bank == BANK_MODULE && instr == CMD_STORE_AXIS) begin
      axis_nv[ptype] <= axis_work[ptype];
    end
  end

  // Global parameter memories
  always_ff @(posedge clk_sys_i) begin
    if (state == MPCH_BOOT && auto_restore_i) begin
      glob_work[BANK_USER[1:0]][boot_idx[7:0]] <= glob_nv[BANK_USER[1:0]][boot_idx[7:0]];
    end else if (state == MPCH_EXEC && sum_ok && bank_ok) begin
      if (instr == CMD_SET_GLOBAL) begin
        glob_work[bank[1:0]][ptype] <= value;
      end else if (instr == CMD_RESTORE_GLOBAL) begin
        glob_work[bank[1:0]][ptype] <= glob_nv[bank[1:0]][ptype];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (state == MPCH_EXEC && sum_ok && bank_ok) begin
      if (instr == CMD_SET_GLOBAL && bank == BANK_MODULE) begin
        glob_nv[bank[1:0]][ptype] <= value;
      end else if (instr == CMD_STORE_GLOBAL) begin
        glob_nv[bank[1:0]][ptype] <= glob_work[bank[1:0]][ptype];
      end
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accu_o <= 32'h0;
    end else if (state == MPCH_EXEC && sum_ok) begin
      if (instr == CMD_GET_AXIS && bank == BANK_MODULE && standalone_i) begin
        accu_o <= axis_rd;
      end else if (instr == CMD_GET_GLOBAL && bank_ok) begin
        accu_o <= glob_rd;
      end
    end
  end

  // Reply
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reply_valid_o <= 1'b0;
      reply_status_o <= 8'h00;
      reply_instr_o <= 8'h00;
      reply_value_o <= 32'h0;
    end else begin
      reply_valid_o <= state == MPCH_EXEC;
      if (state == MPCH_EXEC) begin
        reply_instr_o <= instr;
        reply_value_o <= 32'h0;
        if (!sum_ok) begin
          reply_status_o <= ST_BAD_CHECKSUM;
        end else if (instr < CMD_SET_AXIS || instr > CMD_RESTORE_GLOBAL) begin
          reply_status_o <= ST_BAD_CMD;
        end else if (instr <= CMD_RESTORE_AXIS && bank != BANK_MODULE) begin
          reply_status_o <= ST_BAD_VALUE;
        end else if (instr > CMD_RESTORE_AXIS && !bank_ok) begin
          reply_status_o <= ST_BAD_VALUE;
        end else begin
          reply_status_o <= ST_OK;
          if (instr == CMD_GET_AXIS) begin
            reply_value_o <= axis_rd;
          end else if (instr == CMD_GET_GLOBAL) begin
            reply_value_o <= glob_rd;
          end
        end
      end
    end
  end

  // Checks
  sequence s_exec_ok;
    state == MPCH_EXEC && sum_ok;
  endsequence

  sequence s_last_byte;
    state == MPCH_RECV && rx_valid_i && idx == IDX_SUM;
  endsequence

  sequence s_value_byte;
    state == MPCH_RECV && rx_valid_i && idx == IDX_V0;
  endsequence

  sequence s_boot_last;
    state == MPCH_BOOT && boot_idx == 9'(N_PARAM - 1);
  endsequence

  sequence s_reply_pulse;
    reply_valid_o ##1 !reply_valid_o;
  endsequence

  sequence s_exec_axis;
    s_exec_ok ##0 (bank == BANK_MODULE);
  endsequence

  sequence s_exec_global;
    s_exec_ok ##0 bank_ok;
  endsequence

  a_reply_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_EXEC |=> reply_valid_o)
    else $error("reply missing");

  a_reply_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_EXEC |=> s_reply_pulse)
    else $error("reply strobe not a single pulse");

  a_exec_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_EXEC |-> busy_o)
    else $error("bytes accepted while executing");

  a_bad_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr > CMD_RESTORE_GLOBAL) |=> reply_status_o == ST_BAD_CMD)
    else $error("unknown instruction not flagged");

  a_bad_sum_status: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_EXEC && !sum_ok |=> reply_status_o == ST_BAD_CHECKSUM)
    else $error("bad checksum not flagged");

  a_sum_check: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_last_byte |=> sum_ok == ($past(rx_data_i) == $past(sum)))
    else $error("checksum verdict wrong");

  a_bad_sum_accu: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_EXEC && !sum_ok |=> $stable(accu_o))
    else $error("accumulator changed on bad frame");

  a_frame_exec: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_last_byte |=> state == MPCH_EXEC)
    else $error("frame end not executed");

  a_value_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_value_byte |=> value[7:0] == $past(rx_data_i))
    else $error("last value byte not low byte");

  a_boot_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_BOOT |-> busy_o)
    else $error("bytes accepted during boot");

  a_boot_end: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_boot_last |=> state == MPCH_RECV)
    else $error("boot walk did not end");

  a_boot_restore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == MPCH_BOOT && auto_restore_i && boot_idx == 9'(AP_MAX_POS_SPEED)
    |=> max_pos_speed_o == axis_nv[AP_MAX_POS_SPEED])
    else $error("axis parameter not restored at boot");

  a_set_axis_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_SET_AXIS) |=> reply_status_o == ST_OK)
    else $error("axis write not acknowledged");

  a_set_axis_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_SET_AXIS && ptype == AP_MAX_POS_SPEED)
    |=> max_pos_speed_o == $past(value))
    else $error("speed not written");

  a_get_axis_val: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_GET_AXIS && ptype == AP_MAX_POS_SPEED)
    |=> reply_value_o == max_pos_speed_o)
    else $error("axis read value wrong");

  a_direct_accu_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr == CMD_GET_AXIS && !standalone_i) |=> $stable(accu_o))
    else $error("accumulator changed in direct mode");

  a_standalone_accu: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_GET_AXIS && standalone_i) |=> accu_o == reply_value_o)
    else $error("accumulator not loaded");

  a_ok_status: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_STORE_AXIS) |=> reply_status_o == ST_OK)
    else $error("store not acknowledged");

  a_store_axis: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_STORE_AXIS && ptype == AP_MAX_POS_SPEED)
    |=> axis_nv[AP_MAX_POS_SPEED] == max_pos_speed_o)
    else $error("axis parameter not stored");

  a_restore_axis: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_RESTORE_AXIS && ptype == AP_MAX_POS_SPEED)
    |=> max_pos_speed_o == axis_nv[AP_MAX_POS_SPEED])
    else $error("axis parameter not reloaded");

  a_set_global: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_global ##0 (instr == CMD_SET_GLOBAL) |=> glob_work[bank[1:0]][ptype] == $past(value))
    else $error("global parameter not written");

  a_bad_bank: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr == CMD_SET_GLOBAL && !bank_ok) |=> reply_status_o == ST_BAD_VALUE)
    else $error("bad bank not flagged");

  a_bank0_commit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr == CMD_SET_GLOBAL && bank == BANK_MODULE)
    |=> glob_nv[BANK_MODULE[1:0]][ptype] == $past(value))
    else $error("module setting not committed");

  a_get_global_accu: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_global ##0 (instr == CMD_GET_GLOBAL) |=> accu_o == reply_value_o)
    else $error("global read mismatch");

  a_get_global_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_global ##0 (instr == CMD_GET_GLOBAL) |=> reply_status_o == ST_OK)
    else $error("global read not acknowledged");

  a_store_user: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr == CMD_STORE_GLOBAL && bank == BANK_USER)
    |=> glob_nv[BANK_USER[1:0]][ptype] == glob_work[BANK_USER[1:0]][ptype])
    else $error("user variable not stored");

  a_restore_user: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_ok ##0 (instr == CMD_RESTORE_GLOBAL && bank == BANK_USER)
    |=> glob_work[BANK_USER[1:0]][ptype] == glob_nv[BANK_USER[1:0]][ptype])
    else $error("user variable not restored");

  a_set_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_SET_GLOBAL && ptype == GP_SERIAL_ADDR)
    |=> serial_addr_o == $past(value[7:0]))
    else $error("address not written");

  a_pos_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_exec_axis ##0 (instr == CMD_GET_AXIS && ptype == AP_ACTUAL_POS)
    |=> reply_value_o == $past(actual_pos_i))
    else $error("position wrong");
endmodule

// >>> dv/mpch_host.sv
// Host model: sends nine-byte command frames and reports the reply timing.
// Assumes busy_o and reply_valid_o of the handler, one clock, no reset.
module mpch_host (
  // Clock and handler status
  input wire logic clk_sys_i,
  input wire logic busy_i,
  input wire logic reply_valid_i,
  // Command bytes
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  task automatic send(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                      input logic bad, output logic got);
    logic [7:0] fr [9];
    logic [7:0] sum;
    int n;
    fr = '{8'h01, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum += fr[i];
    fr[8] = bad ? ~sum : sum;
    n = 0;
    while (busy_i && n < 400) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    for (int i = 0; i < 9; i++) begin
      rx_valid_o = 1'b1;
      rx_data_o = fr[i];
      @(posedge clk_sys_i);
      #1;
    end
    rx_valid_o = 1'b0;
    rx_data_o = ~fr[8];
    @(posedge clk_sys_i);
    #1;
    got = reply_valid_i && n < 400;
  endtask
endmodule

// >>> dv/test_mpch_top.sv
// Testbench for the parameter command handler: frame table, then resets.
// Assumes the host model drives all command bytes.
module test_mpch_top
  import mpch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] ins, typ, bank;
    logic [31:0] val;
    logic sa;
    logic [7:0] st;
    logic [31:0] rv, ac;
  } mpch_tb_row_t;
  logic clk_sys_i = 1'b0, rst_n_i, standalone_i, auto_restore_i, rx_valid_i, reply_valid_o;
  logic busy_o;
  logic [7:0] rx_data_i, serial_addr_o, reply_status_o, reply_instr_o;
  logic [31:0] actual_pos_i, max_pos_speed_o, reply_value_o, accu_o;
  int err_total = 0;
  int cmp_count = 0;
  mpch_tb_row_t rows [$];
  always #50 clk_sys_i = ~clk_sys_i;
  mpch_top #(.N_PARAM(256)) i_mpch_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .standalone_i(standalone_i), .auto_restore_i(auto_restore_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .actual_pos_i(actual_pos_i), .max_pos_speed_o(max_pos_speed_o),
    .serial_addr_o(serial_addr_o), .reply_valid_o(reply_valid_o),
    .reply_status_o(reply_status_o), .reply_instr_o(reply_instr_o),
    .reply_value_o(reply_value_o), .accu_o(accu_o), .busy_o(busy_o));
  mpch_host i_mpch_host (.clk_sys_i(clk_sys_i), .busy_i(busy_o),
    .reply_valid_i(reply_valid_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
  task automatic cmp32(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] s, e);
    cmp32(n, {24'h000000, s}, {24'h000000, e});
  endtask
  function automatic mpch_tb_row_t mk(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                                      input logic sa, input logic [7:0] st,
                                      input logic [31:0] rv, ac);
    mk = '{ins, typ, bank, val, sa, st, rv, ac};
  endfunction
  task automatic run(input mpch_tb_row_t r, input logic bad);
    logic got;
    standalone_i = r.sa;
    i_mpch_host.send(r.ins, r.typ, r.bank, r.val, bad, got);
    cmp8("reply strobe", {7'h00, got}, 8'h01);
    cmp8("status", reply_status_o, r.st);
    cmp8("instr", reply_instr_o, r.ins);
    cmp32("value", reply_value_o, r.rv);
    cmp32("accu", accu_o, r.ac);
  endtask
  task automatic reboot(input logic ar);
    @(posedge clk_sys_i);
    #1;
    auto_restore_i = ar;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end
  initial begin
    rst_n_i = 1'b0;
    standalone_i = 1'b0;
    auto_restore_i = 1'b0;
    actual_pos_i = 32'h12345678;
    rows.push_back(mk(CMD_SET_AXIS, 8'h04, 8'h00, 32'h3e8, 0, ST_OK, 0, 0));
    rows.push_back(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 32'h3e8, 0));
    rows.push_back(mk(CMD_GET_AXIS, AP_ACTUAL_POS, 8'h00, 0, 1, ST_OK, 32'h12345678,
                      32'h12345678));
    rows.push_back(mk(CMD_STORE_AXIS, 8'h04, 8'h00, 32'h55, 0, ST_OK, 0, 32'h12345678));
    rows.push_back(mk(CMD_SET_AXIS, 8'h04, 8'h00, 32'h5, 0, ST_OK, 0, 32'h12345678));
    rows.push_back(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 32'h5, 32'h12345678));
    rows.push_back(mk(CMD_RESTORE_AXIS, 8'h04, 8'h00, 32'h9, 0, ST_OK, 0, 32'h12345678));
    rows.push_back(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 1, ST_OK, 32'h3e8, 32'h3e8));
    rows.push_back(mk(CMD_SET_GLOBAL, GP_SERIAL_ADDR, BANK_MODULE, 3, 0, ST_OK, 0, 32'h3e8));
    rows.push_back(mk(CMD_RESTORE_GLOBAL, GP_SERIAL_ADDR, BANK_MODULE, 8, 0, ST_OK, 0,
                      32'h3e8));
    rows.push_back(mk(CMD_GET_GLOBAL, GP_SERIAL_ADDR, BANK_MODULE, 0, 0, ST_OK, 3, 3));
    rows.push_back(mk(CMD_SET_GLOBAL, 8'h05, BANK_USER, 32'h4d, 0, ST_OK, 0, 3));
    rows.push_back(mk(CMD_STORE_GLOBAL, 8'h05, BANK_USER, 0, 0, ST_OK, 0, 3));
    rows.push_back(mk(CMD_SET_GLOBAL, 8'h05, BANK_USER, 32'h9, 0, ST_OK, 0, 3));
    rows.push_back(mk(CMD_RESTORE_GLOBAL, 8'h05, BANK_USER, 0, 0, ST_OK, 0, 3));
    rows.push_back(mk(CMD_GET_GLOBAL, 8'h05, BANK_USER, 0, 0, ST_OK, 32'h4d, 32'h4d));
    rows.push_back(mk(CMD_SET_GLOBAL, 8'h01, BANK_IRQ, 32'h11, 0, ST_OK, 0, 32'h4d));
    rows.push_back(mk(CMD_GET_GLOBAL, 8'h01, BANK_IRQ, 0, 0, ST_OK, 32'h11, 32'h11));
    rows.push_back(mk(CMD_SET_GLOBAL, 8'h01, 8'h01, 32'h7, 0, ST_BAD_VALUE, 0, 32'h11));
    rows.push_back(mk(CMD_GET_AXIS, 8'h04, 8'h01, 0, 1, ST_BAD_VALUE, 0, 32'h11));
    rows.push_back(mk(8'h0d, 8'h00, 8'h00, 0, 0, ST_BAD_CMD, 0, 32'h11));
    repeat (16) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    foreach (rows[i]) run(rows[i], 1'b0);
    cmp32("speed", max_pos_speed_o, 32'h3e8);
    cmp8("serial", serial_addr_o, 8'h03);
    run(mk(CMD_SET_AXIS, 8'h04, 8'h00, 32'h7, 0, ST_BAD_CHECKSUM, 0, 32'h11), 1'b1);
    run(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 32'h3e8, 32'h11), 1'b0);
    run(mk(CMD_SET_AXIS, 8'h04, 8'h00, 32'h5, 0, ST_OK, 0, 32'h11), 1'b0);
    reboot(1'b1);
    cmp8("busy", {7'h00, busy_o}, 8'h01);
    run(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 32'h3e8, 0), 1'b0);
    run(mk(CMD_GET_GLOBAL, 8'h05, BANK_USER, 0, 0, ST_OK, 32'h4d, 32'h4d), 1'b0);
    run(mk(CMD_GET_GLOBAL, GP_SERIAL_ADDR, BANK_MODULE, 0, 0, ST_OK, 3, 3), 1'b0);
    run(mk(CMD_SET_AXIS, 8'h04, 8'h00, 32'h6, 0, ST_OK, 0, 3), 1'b0);
    reboot(1'b0);
    run(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 32'h6, 0), 1'b0);
    run(mk(CMD_RESTORE_AXIS, 8'h04, 8'h00, 0, 0, ST_OK, 0, 0), 1'b0);
    run(mk(CMD_GET_AXIS, 8'h04, 8'h00, 0, 1, ST_OK, 32'h3e8, 32'h3e8), 1'b0);
    wrap_up();
  end
endmodule
